// >>> logic/ipl_pkg.sv
// package: register map, field layout and carrier types for the priority-level block
package ipl_pkg;

	localparam int NUM_SRC = 17;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_WORD_1 = 6'h01;
	localparam logic [5:0] IDX_WORD_2 = 6'h02;
	localparam logic [5:0] IDX_WORD_3 = 6'h03;
	localparam logic [5:0] IDX_WORD_4 = 6'h04;
	localparam logic [5:0] IDX_STATUS = 6'h10;
	localparam logic [5:0] IDX_MASK = 6'h11;

	localparam logic [7:0] ADDR_WORD_1 = {IDX_WORD_1, 2'h0};
	localparam logic [7:0] ADDR_WORD_2 = {IDX_WORD_2, 2'h0};
	localparam logic [7:0] ADDR_WORD_3 = {IDX_WORD_3, 2'h0};
	localparam logic [7:0] ADDR_WORD_4 = {IDX_WORD_4, 2'h0};
	localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
	localparam logic [7:0] ADDR_MASK = {IDX_MASK, 2'h0};

	// implemented bits; all others read zero and ignore writes
	localparam logic [15:0] WMASK_WORD_1 = 16'h0003;
	localparam logic [15:0] WMASK_WORD_2 = 16'hF3FF;
	localparam logic [15:0] WMASK_WORD_3 = 16'hFFF0;
	localparam logic [15:0] WMASK_WORD_4 = 16'h00FC;

	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [16:0] RESET_SRC = 17'h00000;

	// field codes
	localparam logic [1:0] CODE_OFF = 2'h0;
	localparam logic [1:0] CODE_LVL0 = 2'h1;
	localparam logic [1:0] CODE_LVL1 = 2'h2;
	localparam logic [1:0] CODE_LVL2 = 2'h3;

	// source numbers; a lower number wins among equal levels
	localparam int SRC_CLOCKGEN = 0;
	localparam int SRC_SER_RX_FULL = 1;
	localparam int SRC_SER_RX_ERR = 2;
	localparam int SRC_SER_TX_IDLE = 3;
	localparam int SRC_SER_TX_EMPTY = 4;
	localparam int SRC_SPI_TX_EMPTY = 5;
	localparam int SRC_SPI_RX_FULL = 6;
	localparam int SRC_PORT_A = 7;
	localparam int SRC_CONV_A_DONE = 8;
	localparam int SRC_TIMER3 = 9;
	localparam int SRC_TIMER2 = 10;
	localparam int SRC_TIMER1 = 11;
	localparam int SRC_TIMER0 = 12;
	localparam int SRC_I2C_ADDR = 13;
	localparam int SRC_PWM_FAULT = 14;
	localparam int SRC_PWM_RELOAD = 15;
	localparam int SRC_CONV_ZERO_LIM = 16;

	typedef struct packed {
		logic valid;
		logic [1:0] level;
		logic [4:0] source;
	} ipl_arb_type;

	localparam ipl_arb_type RESET_ARB = '{valid: 1'b0, level: 2'h0, source: 5'h00};

endpackage

// >>> logic/ipl_priority_levels.sv
// module: per-source priority fields, APB register slave and level arbitration
//
// Function
// - codes 01/10/11 give levels 0/1/2
// - code 00 blocks source; reset all 00
// - unused bits read zero, ignore writes
// - clock-generator level from previous word bits 1:0
// - serial rx full 15:14, rx error 13:12
// - serial tx idle 9:8, tx empty 7:6
// - spi tx empty 5:4, rx full 3:2
// - port A pin change bits 1:0
// - converter A done word 3 bits 15:14
// - timers 3..0 bits 13:12 down to 7:6
// - i2c address match bits 5:4
// - pwm fault word 4 bits 7:6
// - pwm reload word 4 bits 5:4
// - converter zero/limit word 4 bits 3:2
// - words at indices 2,3,4; status next at index 16
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module ipl_priority_levels (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [16:0] i_req,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output ipl_pkg::ipl_arb_type o_arb,
	output logic o_int
);

	logic [15:0] word1_q;
	logic [15:0] word2_q;
	logic [15:0] word3_q;
	logic [15:0] word4_q;
	logic [16:0] status_q;
	logic [16:0] mask_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic rd_status_q;
	ipl_pkg::ipl_arb_type arb_q;
	ipl_pkg::ipl_arb_type arb_d;
	logic int_q;
	logic [1:0] code [ipl_pkg::NUM_SRC];
	logic [16:0] active;
	logic setup;
	logic done;
	logic wr_done;
	logic mapped;

	assign setup = i_psel && !i_penable;
	assign done = i_psel && i_penable && pready_q;
	assign wr_done = done && i_pwrite && !pslverr_q;

	always_comb begin
		case (i_paddr)
			ipl_pkg::ADDR_WORD_1,
			ipl_pkg::ADDR_WORD_2,
			ipl_pkg::ADDR_WORD_3,
			ipl_pkg::ADDR_WORD_4,
			ipl_pkg::ADDR_STATUS,
			ipl_pkg::ADDR_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// field extraction from the priority words
	assign code[ipl_pkg::SRC_CLOCKGEN] = word1_q[1:0];
	assign code[ipl_pkg::SRC_SER_RX_FULL] = word2_q[15:14];
	assign code[ipl_pkg::SRC_SER_RX_ERR] = word2_q[13:12];
	assign code[ipl_pkg::SRC_SER_TX_IDLE] = word2_q[9:8];
	assign code[ipl_pkg::SRC_SER_TX_EMPTY] = word2_q[7:6];
	assign code[ipl_pkg::SRC_SPI_TX_EMPTY] = word2_q[5:4];
	assign code[ipl_pkg::SRC_SPI_RX_FULL] = word2_q[3:2];
	assign code[ipl_pkg::SRC_PORT_A] = word2_q[1:0];
	assign code[ipl_pkg::SRC_CONV_A_DONE] = word3_q[15:14];
	assign code[ipl_pkg::SRC_TIMER3] = word3_q[13:12];
	assign code[ipl_pkg::SRC_TIMER2] = word3_q[11:10];
	assign code[ipl_pkg::SRC_TIMER1] = word3_q[9:8];
	assign code[ipl_pkg::SRC_TIMER0] = word3_q[7:6];
	assign code[ipl_pkg::SRC_I2C_ADDR] = word3_q[5:4];
	assign code[ipl_pkg::SRC_PWM_FAULT] = word4_q[7:6];
	assign code[ipl_pkg::SRC_PWM_RELOAD] = word4_q[5:4];
	assign code[ipl_pkg::SRC_CONV_ZERO_LIM] = word4_q[3:2];

	// a source with code 00 never requests
	genvar g;
	generate
		for (g = 0; g < ipl_pkg::NUM_SRC; g++) begin : g_act
			assign active[g] = i_req[g] && (code[g] != ipl_pkg::CODE_OFF);
		end
	endgenerate

	// priority words; only implemented bits take write data
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			word1_q <= ipl_pkg::RESET_WORD;
			word2_q <= ipl_pkg::RESET_WORD;
			word3_q <= ipl_pkg::RESET_WORD;
			word4_q <= ipl_pkg::RESET_WORD;
		end else if (wr_done) begin
			case (i_paddr)
				ipl_pkg::ADDR_WORD_1: word1_q <= i_pwdata[15:0] & ipl_pkg::WMASK_WORD_1;
				ipl_pkg::ADDR_WORD_2: word2_q <= i_pwdata[15:0] & ipl_pkg::WMASK_WORD_2;
				ipl_pkg::ADDR_WORD_3: word3_q <= i_pwdata[15:0] & ipl_pkg::WMASK_WORD_3;
				ipl_pkg::ADDR_WORD_4: word4_q <= i_pwdata[15:0] & ipl_pkg::WMASK_WORD_4;
				default: begin
				end
			endcase
		end
	end

	// mask register
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			mask_q <= ipl_pkg::RESET_SRC;
		end else if (wr_done && (i_paddr == ipl_pkg::ADDR_MASK)) begin
			mask_q <= i_pwdata[16:0];
		end
	end

	// sticky status; read clears only what was returned, a new set wins
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			status_q <= ipl_pkg::RESET_SRC;
		end else if (done && !i_pwrite && rd_status_q) begin
			status_q <= (status_q & ~prdata_q[16:0]) | active;
		end else begin
			status_q <= status_q | active;
		end
	end

	// APB answer: read data and ready prepared at the setup edge
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			rd_status_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !mapped;
			rd_status_q <= setup && !i_pwrite && (i_paddr == ipl_pkg::ADDR_STATUS);
			if (setup && !i_pwrite) begin
				case (i_paddr)
					ipl_pkg::ADDR_WORD_1: prdata_q <= {16'h0000, word1_q};
					ipl_pkg::ADDR_WORD_2: prdata_q <= {16'h0000, word2_q};
					ipl_pkg::ADDR_WORD_3: prdata_q <= {16'h0000, word3_q};
					ipl_pkg::ADDR_WORD_4: prdata_q <= {16'h0000, word4_q};
					ipl_pkg::ADDR_STATUS: prdata_q <= {15'h0000, status_q};
					ipl_pkg::ADDR_MASK: prdata_q <= {15'h0000, mask_q};
					default: prdata_q <= 32'h00000000;
				endcase
			end else if (done) begin
				prdata_q <= 32'h00000000;
			end
		end
	end

	// highest code wins; scanning downward with >= keeps the lowest source on a tie
	always_comb begin
		logic [1:0] best;
		best = ipl_pkg::CODE_OFF;
		arb_d = ipl_pkg::RESET_ARB;
		for (int k = ipl_pkg::NUM_SRC - 1; k >= 0; k--) begin
			if (active[k] && (code[k] >= best)) begin
				best = code[k];
				arb_d.valid = 1'b1;
				arb_d.source = 5'(k);
			end
		end
		arb_d.level = arb_d.valid ? best - 2'h1 : 2'h0;
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			arb_q <= ipl_pkg::RESET_ARB;
			int_q <= 1'b0;
		end else begin
			arb_q <= arb_d;
			int_q <= |(status_q & mask_q);
		end
	end

	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_arb = arb_q;
	assign o_int = int_q;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);

	a_level_range: assert property (o_arb.valid |-> o_arb.level != 2'h3)
		else $error("presented level above 2");

	a_top_code_level: assert property ((active[ipl_pkg::SRC_TIMER0] && code[ipl_pkg::SRC_TIMER0] == ipl_pkg::CODE_LVL2)
		|=> (o_arb.valid && o_arb.level == 2'h2))
		else $error("code 11 did not give level 2");

	a_off_blocks: assert property ($rose(status_q[ipl_pkg::SRC_PORT_A])
		|-> $past(word2_q[1:0]) != ipl_pkg::CODE_OFF)
		else $error("disabled source set status");

	a_reserved_zero: assert property (done && !i_pwrite && i_paddr == ipl_pkg::ADDR_WORD_4
		|-> o_prdata[31:8] == 24'h000000 && o_prdata[1:0] == 2'h0)
		else $error("reserved bits read nonzero");

	a_clockgen_write: assert property (wr_done && i_paddr == ipl_pkg::ADDR_WORD_1
		|=> code[ipl_pkg::SRC_CLOCKGEN] == $past(i_pwdata[1:0]))
		else $error("clock-generator field not written");

	a_serial_write: assert property (wr_done && i_paddr == ipl_pkg::ADDR_WORD_2
		|=> code[ipl_pkg::SRC_SER_RX_FULL] == $past(i_pwdata[15:14])
		&& code[ipl_pkg::SRC_SER_TX_IDLE] == $past(i_pwdata[9:8])
		&& code[ipl_pkg::SRC_SPI_RX_FULL] == $past(i_pwdata[3:2]))
		else $error("word 2 fields not written");

	a_timer_write: assert property (wr_done && i_paddr == ipl_pkg::ADDR_WORD_3
		|=> code[ipl_pkg::SRC_TIMER3] == $past(i_pwdata[13:12])
		&& code[ipl_pkg::SRC_TIMER0] == $past(i_pwdata[7:6]))
		else $error("timer fields not written");

	a_pwm_write: assert property (wr_done && i_paddr == ipl_pkg::ADDR_WORD_4
		|=> code[ipl_pkg::SRC_PWM_FAULT] == $past(i_pwdata[7:6])
		&& code[ipl_pkg::SRC_CONV_ZERO_LIM] == $past(i_pwdata[3:2]))
		else $error("word 4 fields not written");

	a_arb_idle: assert property (active == 17'h00000 |=> !o_arb.valid)
		else $error("request shown with none active");

	a_tie_order: assert property (active[ipl_pkg::SRC_TIMER1] && active[ipl_pkg::SRC_TIMER2]
		&& code[ipl_pkg::SRC_TIMER1] == ipl_pkg::CODE_LVL2 && code[ipl_pkg::SRC_TIMER2] == ipl_pkg::CODE_LVL2
		|=> o_arb.valid && o_arb.level == 2'h2 && o_arb.source <= 5'(ipl_pkg::SRC_TIMER2))
		else $error("tie not resolved to lower source");

	a_ready_next: assert property (setup |=> o_pready ##1 !o_pready)
		else $error("ready not one cycle after setup");

endmodule // ipl_priority_levels

// >>> dv/ipl_req_model.sv
// peripheral request model: registers request lines toward the block
`timescale 1ns/100ps
module ipl_req_model (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [16:0] i_set,
	output logic [16:0] o_req
);
	// requests change only on the clock, like peripheral flags
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_req <= 17'h00000;
		end else begin
			o_req <= i_set;
		end
	end
endmodule // ipl_req_model

// >>> dv/ipl_priority_levels_test.sv
// self-checking bench for the priority-level block
`timescale 1ns/100ps
module ipl_priority_levels_test;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [16:0] req_cmd = 17'h00000;
	logic [16:0] req;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	ipl_pkg::ipl_arb_type arb;
	logic [15:0] sh [1:4];
	logic [15:0] wm [1:4] = '{ipl_pkg::WMASK_WORD_1, ipl_pkg::WMASK_WORD_2, ipl_pkg::WMASK_WORD_3, ipl_pkg::WMASK_WORD_4};
	logic [31:0] rd;
	logic err;
	integer seed = 62;
	int w;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	int w_of [17] = '{1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 4, 4, 4};
	int l_of [17] = '{0, 14, 12, 8, 6, 4, 2, 0, 14, 12, 10, 8, 6, 4, 6, 4, 2};
	always #20 i_mclk = ~i_mclk;
	ipl_req_model peer (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_set(req_cmd), .o_req(req));
	ipl_priority_levels dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_req(req), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_arb(arb), .o_int(irq));
	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			tally_and_finish;
		end
	end
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// response taken at the rising edge that samples pready high, then released
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_mclk);
		pen <= 1'b1;
		@(posedge i_mclk);
		while (pready !== 1'b1) @(posedge i_mclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wrw(input int wi, input logic [15:0] d);
		apb(1'b1, 8'(wi * 4), {16'h0000, d});
		sh[wi] = d & wm[wi];
	endtask
	function automatic logic [7:0] exp_arb(input logic [16:0] r);
		logic [1:0] c;
		logic [7:0] e;
		e = 8'h00;
		for (int s = 0; s < 17; s++) begin
			c = 2'(sh[w_of[s]] >> l_of[s]);
			if (r[s] && c != 2'h0 && (!e[7] || c - 2'h1 > e[6:5])) e = {1'b1, c - 2'h1, 5'(s)};
		end
		return e;
	endfunction
	task arb_step(input logic [16:0] v);
		logic [7:0] e;
		@(posedge i_mclk);
		req_cmd <= v;
		repeat (2) @(posedge i_mclk);
		@(negedge i_mclk);
		e = exp_arb(v);
		if (e[7]) chk("arb", {24'h000000, e}, {24'h000000, arb});
		else chk("arb valid", 32'h0, {31'h0, arb.valid});
	endtask
	initial begin
		repeat (12) @(posedge i_mclk);
		i_rstn <= 1'b1;
		for (w = 1; w <= 4; w++) begin
			apb(1'b0, 8'(w * 4), 32'h0);
			chk("reset word", 32'h0, rd);
			apb(1'b1, 8'(w * 4), 32'hFFFFFFFF);
			apb(1'b0, 8'(w * 4), 32'h0);
			chk("word bits", {16'h0000, wm[w]}, rd);
			sh[w] = wm[w];
		end
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		arb_step(17'h1FFFF);
		apb(1'b1, ipl_pkg::ADDR_MASK, 32'h0001FFFF);
		arb_step(17'h00000);
		apb(1'b0, ipl_pkg::ADDR_STATUS, 32'h0);
		apb(1'b0, ipl_pkg::ADDR_STATUS, 32'h0);
		chk("status cleared", 32'h0, rd);
		@(negedge i_mclk);
		chk("int idle", 32'h0, {31'h0, irq});
		arb_step(17'h01000);
		arb_step(17'h00000);
		chk("int raised", 32'h1, {31'h0, irq});
		apb(1'b0, ipl_pkg::ADDR_STATUS, 32'h0);
		chk("status sticky", 32'h00001000, rd);
		@(posedge i_mclk);
		@(negedge i_mclk);
		chk("int cleared", 32'h0, {31'h0, irq});
		apb(1'b1, ipl_pkg::ADDR_MASK, 32'h0);
		arb_step(17'h00008);
		arb_step(17'h00000);
		chk("int masked", 32'h0, {31'h0, irq});
		apb(1'b0, ipl_pkg::ADDR_STATUS, 32'h0);
		chk("status masked", 32'h00000008, rd);
		for (w = 1; w <= 4; w++) wrw(w, (w == 3) ? 16'h0040 : 16'h0000);
		arb_step(17'h01080);
		for (int i = 0; i < 80; i++) begin
			w = 1 + ($unsigned($random(seed)) % 4);
			wrw(w, 16'($random(seed)));
			arb_step(17'($random(seed) & $random(seed)));
		end
		tally_and_finish;
	end
endmodule // ipl_priority_levels_test
